/* File: power_mgmt_pkg.sv */
// Shared constants and types for the power management control registers
package power_mgmt_pkg;

  // ==========================================================================
  // Register map and serial command layout
  localparam logic [5:0] POWER_CONTROL_ADDR   = 6'h0b;
  localparam logic [5:0] CRYSTAL_CONTROL_ADDR = 6'h0c;
  localparam int         CMD_WRITE_BIT        = 7;
  localparam int         CMD_INCR_BIT         = 6;
  localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

  // ==========================================================================
  // Reset values and writable bits
  localparam logic [7:0] POWER_CONTROL_RESET    = 8'ha0;
  localparam logic [7:0] POWER_CONTROL_WMASK    = 8'hef;
  localparam logic [7:0] CRYSTAL_CONTROL_RESET  = 8'h04;
  localparam logic [7:0] CRYSTAL_CONTROL_WMASK  = 8'he7;

  // ==========================================================================
  // Trip and regulator levels in millivolts
  localparam int          TRIP_MV_W       = 12;
  localparam logic [11:0] THRESH_11_MV    = 12'h708;  // 1800 mV
  localparam logic [11:0] THRESH_10_MV    = 12'h7d0;  // 2000 mV
  localparam logic [11:0] THRESH_01_MV    = 12'h898;  // 2200 mV
  localparam logic [11:0] MIN_OUT_11_MV   = 12'h960;  // 2400 mV
  localparam logic [11:0] MIN_OUT_10_MV   = 12'h9c4;  // 2500 mV
  localparam logic [11:0] MIN_OUT_01_MV   = 12'ha28;  // 2600 mV
  localparam logic [11:0] MIN_OUT_00_MV   = 12'ha8c;  // 2700 mV

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_ADDR = 2'b01,
    PHASE_DATA = 2'b10
  } spi_phase_t;

  typedef struct packed {
    logic       regulator_enable;
    logic       low_batt_event_enable;
    logic       regulator_sleep_override;
    logic       reserved;
    logic [1:0] low_batt_threshold;
    logic [1:0] regulator_min_output;
  } power_control_t;

  typedef struct packed {
    logic [1:0] clock_pin_function;
    logic       crystal_stable_event_enable;
    logic [1:0] reserved;
    logic [2:0] clock_out_divider;
  } crystal_control_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_n;
  } spi_in_t;

  typedef struct packed {
    logic miso;
    logic miso_oe_n;
  } spi_out_t;

endpackage : power_mgmt_pkg

/* File: input_sync.sv */
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
module input_sync #(
  parameter int              WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage1;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // ==========================================================================
  // Next state: first stage feeds only the second
  always_comb begin
    next_state.stage1 = d;
    next_state.stage2 = state.stage1;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= {RESET_VALUE, RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign q = state.stage2;

endmodule : input_sync

/* File: trip_level_decode.sv */
// Decodes threshold and regulator codes into a trip level in millivolts
`timescale 1ns/100ps
module trip_level_decode
  import power_mgmt_pkg::*;
(
  input  wire logic [1:0]           low_batt_threshold,
  input  wire logic [1:0]           regulator_min_output,
  output logic      [TRIP_MV_W-1:0] trip_mv
);

  logic [TRIP_MV_W-1:0] min_out_mv;

  // ==========================================================================
  // Regulator minimum output level
  always_comb begin
    case (regulator_min_output)
      2'h3:    min_out_mv = MIN_OUT_11_MV;
      2'h2:    min_out_mv = MIN_OUT_10_MV;
      2'h1:    min_out_mv = MIN_OUT_01_MV;
      default: min_out_mv = MIN_OUT_00_MV;
    endcase
  end

  // ==========================================================================
  // Battery trip level, code 0 follows the regulator setting
  always_comb begin
    case (low_batt_threshold)
      2'h3:    trip_mv = THRESH_11_MV;
      2'h2:    trip_mv = THRESH_10_MV;
      2'h1:    trip_mv = THRESH_01_MV;
      default: trip_mv = min_out_mv;
    endcase
  end

endmodule : trip_level_decode

/* File: power_mgmt_control_regs.sv */
// Power control and crystal control registers behind the serial register port
`timescale 1ns/100ps
module power_mgmt_control_regs (
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_n,
  input  wire power_mgmt_pkg::spi_in_t                 spi_in,
  output power_mgmt_pkg::spi_out_t                     spi_out,
  input  wire logic                                    sleep_active,
  input  wire logic                                    batt_below_threshold,
  output logic                                         regulator_on,
  output logic                                         low_batt_event,
  output logic [1:0]                                   low_batt_threshold,
  output logic [1:0]                                   regulator_min_output,
  output logic [power_mgmt_pkg::TRIP_MV_W-1:0]         trip_level_mv,
  output logic [1:0]                                   clock_pin_function,
  output logic                                         crystal_stable_event_enable,
  output logic [2:0]                                   clock_out_divider
);
  import power_mgmt_pkg::*;

  // ==========================================================================
  // State of the block
  typedef struct packed {
    spi_phase_t           phase;
    logic [2:0]           bit_count;
    logic [7:0]           rx_shift;
    logic [7:0]           tx_shift;
    logic [5:0]           address;
    logic                 write_flag;
    logic                 increment_flag;
    logic                 sck_prev;
    power_control_t       pwr;
    crystal_control_t     xtal;
    spi_out_t             pins;
    logic                 regulator_on;
    logic                 low_batt_event;
    logic [TRIP_MV_W-1:0] trip_mv;
  } block_state_t;

  block_state_t         state;
  block_state_t         next_state;
  spi_in_t              spi_sync;
  logic                 batt_below_sync;
  logic                 sck_rise;
  logic                 sck_fall;
  logic [7:0]           rx_byte;
  logic [5:0]           next_address;
  logic [TRIP_MV_W-1:0] decoded_trip_mv;
  logic                 regulator_active;

  // ==========================================================================
  // Synchronisers for the serial pins
  input_sync #(
    .WIDTH       (3),
    .RESET_VALUE (3'h1)
  ) u_spi_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (spi_in),
    .q       (spi_sync)
  );

  // Synchroniser for the battery comparator
  input_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'h0)
  ) u_batt_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (batt_below_threshold),
    .q       (batt_below_sync)
  );

  // ==========================================================================
  // Trip level decode from current register fields
  trip_level_decode u_trip_decode (
    .low_batt_threshold   (state.pwr.low_batt_threshold),
    .regulator_min_output (state.pwr.regulator_min_output),
    .trip_mv              (decoded_trip_mv)
  );

  // ==========================================================================
  // Register read with reserved bits as zero
  function automatic logic [7:0] read_reg(
    input logic [5:0]       addr,
    input power_control_t   pwr,
    input crystal_control_t xtal
  );
    logic [7:0] value;
    value = UNMAPPED_READ_VALUE;
    if (addr == POWER_CONTROL_ADDR) begin
      value = pwr & POWER_CONTROL_WMASK;
    end else if (addr == CRYSTAL_CONTROL_ADDR) begin
      value = xtal & CRYSTAL_CONTROL_WMASK;
    end
    return value;
  endfunction : read_reg

  // ==========================================================================
  // Serial clock edges and incoming byte
  assign sck_rise     = spi_sync.sck & ~state.sck_prev;
  assign sck_fall     = ~spi_sync.sck & state.sck_prev;
  assign rx_byte      = {state.rx_shift[6:0], spi_sync.mosi};
  assign next_address = state.increment_flag ? state.address + 6'h01 : state.address;

  // Regulator on when enabled, unless sleeping without override
  assign regulator_active = state.pwr.regulator_enable
                          & (state.pwr.regulator_sleep_override | ~sleep_active);

  // ==========================================================================
  // Next state
  always_comb begin
    next_state          = state;
    next_state.sck_prev = spi_sync.sck;

    if (spi_sync.ss_n) begin
      // Deselected: end transfer and release the output
      next_state.phase          = PHASE_IDLE;
      next_state.bit_count      = 3'h0;
      next_state.pins.miso      = 1'b0;
      next_state.pins.miso_oe_n = 1'b1;
    end else begin
      next_state.pins.miso_oe_n = 1'b0;
      if (state.phase == PHASE_IDLE) begin
        next_state.phase     = PHASE_ADDR;
        next_state.bit_count = 3'h0;
        next_state.tx_shift  = 8'h00;
        next_state.pins.miso = 1'b0;
      end else if (sck_rise) begin
        next_state.rx_shift  = rx_byte;
        next_state.bit_count = state.bit_count + 3'h1;
        if (state.bit_count == 3'h7) begin
          case (state.phase)
            PHASE_ADDR: begin
              next_state.write_flag     = rx_byte[CMD_WRITE_BIT];
              next_state.increment_flag = rx_byte[CMD_INCR_BIT];
              next_state.address        = rx_byte[5:0];
              next_state.tx_shift       = read_reg(rx_byte[5:0], state.pwr, state.xtal);
              next_state.phase          = PHASE_DATA;
            end
            PHASE_DATA: begin
              if (state.write_flag && state.address == POWER_CONTROL_ADDR) begin
                next_state.pwr = (rx_byte & POWER_CONTROL_WMASK) | (state.pwr & ~POWER_CONTROL_WMASK);
              end
              if (state.write_flag && state.address == CRYSTAL_CONTROL_ADDR) begin
                next_state.xtal = (rx_byte & CRYSTAL_CONTROL_WMASK) | (state.xtal & ~CRYSTAL_CONTROL_WMASK);
              end
              next_state.address  = next_address;
              next_state.tx_shift = read_reg(next_address, next_state.pwr, next_state.xtal);
            end
            default: begin
              next_state.phase = PHASE_IDLE;
            end
          endcase
        end
      end else if (sck_fall) begin
        // Present next read bit, MSB first
        next_state.pins.miso = state.tx_shift[7];
        next_state.tx_shift  = {state.tx_shift[6:0], 1'b0};
      end
    end

    // Regulator control and low battery event
    next_state.regulator_on   = regulator_active;
    next_state.low_batt_event = state.pwr.low_batt_event_enable
                              & batt_below_sync
                              & ~sleep_active
                              & regulator_active;
    next_state.trip_mv        = decoded_trip_mv;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state                <= '0;
      state.phase          <= PHASE_IDLE;
      state.sck_prev       <= 1'b0;
      state.pwr            <= POWER_CONTROL_RESET;
      state.xtal           <= CRYSTAL_CONTROL_RESET;
      state.pins.miso_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs straight from state
  assign spi_out                     = state.pins;
  assign regulator_on                = state.regulator_on;
  assign low_batt_event              = state.low_batt_event;
  assign low_batt_threshold          = state.pwr.low_batt_threshold;
  assign regulator_min_output        = state.pwr.regulator_min_output;
  assign trip_level_mv               = state.trip_mv;
  assign clock_pin_function          = state.xtal.clock_pin_function;
  assign crystal_stable_event_enable = state.xtal.crystal_stable_event_enable;
  assign clock_out_divider           = state.xtal.clock_out_divider;

endmodule : power_mgmt_control_regs

/* File: power_mgmt_control_regs_asserts.sv */
// Port level checks for the power management control registers
`timescale 1ns/100ps
module power_mgmt_control_regs_asserts (
  input wire logic                                clk_sys,
  input wire logic                                rst_n,
  input wire power_mgmt_pkg::spi_in_t             spi_in,
  input wire power_mgmt_pkg::spi_out_t            spi_out,
  input wire logic                                sleep_active,
  input wire logic                                batt_below_threshold,
  input wire logic                                regulator_on,
  input wire logic                                low_batt_event,
  input wire logic [1:0]                          low_batt_threshold,
  input wire logic [1:0]                          regulator_min_output,
  input wire logic [power_mgmt_pkg::TRIP_MV_W-1:0] trip_level_mv
);
  import power_mgmt_pkg::*;
  logic [11:0] min_mv;
  logic [11:0] fix_mv;
  // ==========================================================
  // Expected levels from the field codes
  assign min_mv = (regulator_min_output == 2'h3) ? MIN_OUT_11_MV : (regulator_min_output == 2'h2) ? MIN_OUT_10_MV :
                  (regulator_min_output == 2'h1) ? MIN_OUT_01_MV : MIN_OUT_00_MV;
  assign fix_mv = (low_batt_threshold == 2'h3) ? THRESH_11_MV : (low_batt_threshold == 2'h2) ? THRESH_10_MV : THRESH_01_MV;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  sequence s_desel;
    spi_in.ss_n [*4];
  endsequence
  sequence s_sel;
    (!spi_in.ss_n) [*4];
  endsequence
  sequence s_fields_held;
    $stable(low_batt_threshold) && $stable(regulator_min_output);
  endsequence
  // ==========================================================
  // Assertions
  AST_EVENT_NEEDS_LOW_BATT: assert property (low_batt_event |-> $past(batt_below_threshold, 3))
    else $error("low battery event without low battery");
  AST_NO_EVENT_IN_SLEEP: assert property (sleep_active |=> !low_batt_event)
    else $error("low battery event during sleep");
  AST_NO_EVENT_REG_OFF: assert property (!regulator_on && !$past(regulator_on) |-> !low_batt_event)
    else $error("low battery event while regulator off");
  // Trip level is still at its reset value on the first edge out of reset
  AST_FIXED_TRIP: assert property (s_fields_held and (low_batt_threshold != 2'h0 && $past(rst_n)) |-> trip_level_mv == fix_mv)
    else $error("fixed trip level wrong");
  AST_TRIP_FOLLOWS_MIN: assert property (s_fields_held and (low_batt_threshold == 2'h0 && $past(rst_n)) |-> trip_level_mv == min_mv)
    else $error("trip level not at regulator minimum");
  AST_DESEL_OE_HIGH: assert property (s_desel |-> spi_out.miso_oe_n)
    else $error("read line driven while deselected");
  AST_SEL_OE_LOW: assert property (s_sel |-> !spi_out.miso_oe_n)
    else $error("read line not driven while selected");
  AST_DESEL_MISO_LOW: assert property (spi_out.miso_oe_n |-> !spi_out.miso)
    else $error("read data not low while released");
  AST_MISO_ON_FALL: assert property ($changed(spi_out.miso) |-> $past(!spi_in.sck, 3) || $past(spi_in.ss_n, 3))
    else $error("read data moved without clock fall");
endmodule : power_mgmt_control_regs_asserts

/* File: spi_host_model.sv */
// Host controller model driving the serial register port
`timescale 1ns/100ps
module spi_host_model (
  input  wire logic                     clk_sys,
  output power_mgmt_pkg::spi_in_t       spi_in,
  input  wire power_mgmt_pkg::spi_out_t spi_out
);
  import power_mgmt_pkg::*;
  localparam int HALF = 5;  // Clock phase length in system cycles
  logic miso_line;
  // Released read line floats up to its pull-up level
  assign miso_line = spi_out.miso_oe_n ? 1'b1 : spi_out.miso;
  initial spi_in = 3'b001;
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : gap
  // Command plus one or two data bytes, MSB first, data taken at rising clock
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdat, input int nbytes, output logic [15:0] rdat);
    logic [23:0] sh;
    sh = {cmd, wdat};
    rdat = 16'h0000;
    @(negedge clk_sys);
    spi_in.ss_n = 1'b0;
    gap(HALF);
    for (int i = 23; i >= 24 - 8 * nbytes; i--) begin
      spi_in.mosi = sh[i];
      gap(HALF);
      spi_in.sck = 1'b1;
      if (i < 16) rdat[i] = miso_line;
      gap(HALF);
      spi_in.sck = 1'b0;
    end
    gap(HALF);
    spi_in.ss_n = 1'b1;
    spi_in.mosi = ~spi_in.mosi;  // Released data line shows no stale bit
    gap(HALF);
  endtask : xfer
endmodule : spi_host_model

/* File: power_mgmt_control_regs_tb.sv */
// Self-checking bench for the power management control registers
`timescale 1ns/100ps
module power_mgmt_control_regs_tb;
  import power_mgmt_pkg::*;
  logic clk_sys, rst_n, sleep_active, batt_below_threshold, regulator_on, low_batt_event, crystal_stable_event_enable;
  spi_in_t spi_in;
  spi_out_t spi_out;
  logic [1:0] low_batt_threshold, regulator_min_output, clock_pin_function;
  logic [TRIP_MV_W-1:0] trip_level_mv;
  logic [2:0] clock_out_divider;
  logic [7:0] rd;
  logic [15:0] rd2;
  int bad_count = 0, comparisons = 0, cycles = 0;
  power_mgmt_control_regs power_mgmt_control_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .spi_in(spi_in),
    .spi_out(spi_out), .sleep_active(sleep_active), .batt_below_threshold(batt_below_threshold),
    .regulator_on(regulator_on), .low_batt_event(low_batt_event), .low_batt_threshold(low_batt_threshold),
    .regulator_min_output(regulator_min_output), .trip_level_mv(trip_level_mv), .clock_pin_function(clock_pin_function),
    .crystal_stable_event_enable(crystal_stable_event_enable), .clock_out_divider(clock_out_divider));
  spi_host_model spi_host_model_inst (.clk_sys(clk_sys), .spi_in(spi_in), .spi_out(spi_out));
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    spi_host_model_inst.xfer({2'b10, a}, {d, 8'h00}, 2, rd2);
    repeat (8) @(negedge clk_sys);
  endtask : wr
  task automatic rdreg(input logic [5:0] a);
    spi_host_model_inst.xfer({2'b00, a}, 16'h0000, 2, rd2);
    rd = rd2[15:8];
  endtask : rdreg
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Scenarios
  task automatic test_reset;
    rdreg(POWER_CONTROL_ADDR);
    check("power_control", rd, 8'ha0);
    rdreg(CRYSTAL_CONTROL_ADDR);
    check("crystal_control", rd, 8'h04);
    check("regulator_on", regulator_on, 1'b1);
  endtask : test_reset
  task automatic test_modes;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];  // Enable, override, sleep
      sleep_active = m[0];
      wr(POWER_CONTROL_ADDR, {m[2], 1'b0, m[1], 5'h00});
      check("regulator_on", regulator_on, m[1] ? m[2] : m[2] & ~m[0]);
    end
  endtask : test_modes
  task automatic test_levels;
    logic [11:0] mins [4] = '{12'ha8c, 12'ha28, 12'h9c4, 12'h960};
    logic [11:0] ths [4] = '{12'h000, 12'h898, 12'h7d0, 12'h708};
    for (int i = 0; i < 16; i++) begin
      wr(POWER_CONTROL_ADDR, {4'ha, i[3:0]});
      check("low_batt_threshold", low_batt_threshold, i[3:2]);
      check("regulator_min_output", regulator_min_output, i[1:0]);
      check("trip_level_mv", trip_level_mv, (i[3:2] == 2'h0) ? mins[i[1:0]] : ths[i[3:2]]);
    end
  endtask : test_levels
  task automatic test_event;
    sleep_active = 1'b0;
    batt_below_threshold = 1'b1;
    wr(POWER_CONTROL_ADDR, 8'hc0);
    check("low_batt_event", low_batt_event, 1'b1);
    sleep_active = 1'b1;
    wr(POWER_CONTROL_ADDR, 8'he0);
    check("low_batt_event", low_batt_event, 1'b0);
    sleep_active = 1'b0;
    wr(POWER_CONTROL_ADDR, 8'h60);
    check("low_batt_event", low_batt_event, 1'b0);
    wr(POWER_CONTROL_ADDR, 8'h80);
    check("low_batt_event", low_batt_event, 1'b0);
    batt_below_threshold = 1'b0;
    wr(POWER_CONTROL_ADDR, 8'hc0);
    check("low_batt_event", low_batt_event, 1'b0);
  endtask : test_event
  task automatic test_map;
    wr(CRYSTAL_CONTROL_ADDR, 8'hff);
    rdreg(CRYSTAL_CONTROL_ADDR);
    check("crystal_control", rd, 8'he7);
    check("crystal_fields", {clock_pin_function, crystal_stable_event_enable, clock_out_divider}, 6'h3f);
    wr(POWER_CONTROL_ADDR, 8'hff);
    wr(6'h20, 8'h5a);
    rdreg(6'h20);
    check("unmapped", rd, 8'h00);
    rdreg(POWER_CONTROL_ADDR);
    check("power_control", rd, 8'hef);
  endtask : test_map
  // Incrementing write and read across both registers, then a repeating read
  task automatic test_burst;
    spi_host_model_inst.xfer({2'b11, POWER_CONTROL_ADDR}, 16'h8e45, 3, rd2);
    repeat (8) @(negedge clk_sys);
    check("burst_old_values", rd2, 16'hefe7);
    check("burst_fields", {low_batt_threshold, regulator_min_output, clock_pin_function, clock_out_divider}, 9'h1cd);
    spi_host_model_inst.xfer({2'b01, POWER_CONTROL_ADDR}, 16'h0000, 3, rd2);
    check("burst_read", rd2, 16'h8e45);
    spi_host_model_inst.xfer({2'b00, POWER_CONTROL_ADDR}, 16'h0000, 3, rd2);
    check("repeat_read", rd2, 16'h8e8e);
  endtask : test_burst
  // ==========================================================
  // Clock, sequence and timeout
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    sleep_active = 1'b1;
    batt_below_threshold = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    test_reset;
    test_modes;
    test_levels;
    test_event;
    test_map;
    test_burst;
    wrap_up;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up;
    end
  end
endmodule : power_mgmt_control_regs_tb
bind power_mgmt_control_regs power_mgmt_control_regs_asserts power_mgmt_control_regs_asserts_inst (.clk_sys(clk_sys),
  .rst_n(rst_n), .spi_in(spi_in), .spi_out(spi_out), .sleep_active(sleep_active),
  .batt_below_threshold(batt_below_threshold), .regulator_on(regulator_on), .low_batt_event(low_batt_event),
  .low_batt_threshold(low_batt_threshold), .regulator_min_output(regulator_min_output), .trip_level_mv(trip_level_mv));
